//--- pmc_mode_ctrl.sv
/*
 * Operating mode controller: run, debug-halt, wait and stop, with
 * debug command gating, wake handling and low-power control outputs.
 * Assumes the CPU reports its halt, wait and stop instructions as
 * one-cycle pulses and obeys cpu_clk_en_q and the restart strobe.
 */
// Functional notes
// - Mode pin high at reset release gives run mode, start at 3FFD.
// - Mode pin low at power-on or force-reset command gives debug-halt.
// - Halt request command from debug host enters debug-halt.
// - Debug halt instruction or breakpoint match enters debug-halt.
// - In debug-halt the CPU stays suspended, only debug commands served.
// - Non-intrusive commands accepted in run and in debug-halt.
// - Register, trace and resume commands honoured only in debug-halt.
// - Wait stops CPU clock, holds program counter, system clocks keep running.
// - Any interrupt in wait resumes at program counter plus one.
// - In wait or stop only halt and status access pass, status reports error.
// - Halt request during wait goes straight to debug-halt.
// - During wait system clocks run and pin states are held.
// - Stop instruction with stop enable set halts CPU and system clocks.
// - Stop instruction with stop enable clear forces illegal-opcode reset.
// - In stop clock generator off unless debug allow or keep bit with both low-volt bits, regulator standby, state kept.
// - Stop exits on reset pin, enabled asynchronous wake, or periodic wake.
// - Reset-pin exit restarts at 3FFD; interrupt exit continues after stop.
// - Rate select 000 disables periodic wake and its 1 kHz oscillator.
// - Reference clock runs with keep bit; in stop also needs both low-volt bits.
// - Debug allow bit keeps debug clocks and regulation in stop; halt wakes.
// - Low-volt detect and low-volt stop both enabled in stop keep regulator active.
`include "pmc_params.svh"

module pmc_mode_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_select_debug_pin,
    input wire logic por_flag,
    input wire logic debug_force_reset_cmd,
    input wire logic dbg_cmd_valid,
    input wire logic [1:0] dbg_cmd_class,
    input wire logic dbg_cmd_halt,
    input wire logic debug_halt_instruction,
    input wire logic breakpoint_match,
    input wire logic wait_instruction,
    input wire logic stop_instruction,
    input wire logic irq_request,
    input wire logic [`PMC_WAKE_W-1:0] async_wake_req,
    input wire logic periodic_wake_req,
    input wire logic reset_pin_req,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpu_clk_en_q,
    output logic sys_clk_en_q,
    output logic dbg_clk_en_q,
    output logic clkgen_en_q,
    output logic ref_clk_en_q,
    output logic wake_osc_en_q,
    output logic reg_full_q,
    output logic pin_hold_q,
    output logic restart_q,
    output logic [`PMC_ADDR_W-1:0] restart_addr_q,
    output logic pc_advance_q,
    output logic illegal_op_reset_q,
    output logic dbg_cmd_accept_q,
    output logic dbg_cmd_err_q,
    output logic dbg_mem_allow_q
);
    pmc_wake_if wake_bus ();
    pmc_pkg::pmc_state_t state_q;
    pmc_pkg::pmc_state_t state_d;
    logic [31:0] ctrl_q;
    logic [31:0] wake_en_q;
    logic [31:0] status_word;
    logic stop_enable_bit;
    logic ref_keep;
    logic lv_stop;
    logic dbg_allow;
    logic rate_on;
    logic in_halt;
    logic in_low;
    logic halt_cmd;
    logic class_ok;
    logic status_cmd;
    logic async_hit;
    logic stop_wake;
    logic go_cmd;
    logic enter_halt;
    logic reset_exit;
    logic ilop;
    logic [1:0] sync_cnt_q;

    pmc_axi_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .status_word(status_word),
        .ctrl_q(ctrl_q),
        .wake_en_q(wake_en_q)
    );

    pmc_wake_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(async_wake_req),
        .periodic_in(periodic_wake_req),
        .reset_pin_in(reset_pin_req),
        .wake(wake_bus.src)
    );

    // Control fields
    assign stop_enable_bit = ctrl_q[`PMC_CTRL_STOP_ENABLE_BIT_BIT];
    assign ref_keep = ctrl_q[`PMC_CTRL_REFKEEP_BIT];
    assign lv_stop = ctrl_q[`PMC_CTRL_LOWVOLT_DETECT_ENABLE_BIT] && ctrl_q[`PMC_CTRL_LOWVOLT_STOP_ENABLE_BIT];
    assign dbg_allow = ctrl_q[`PMC_CTRL_DBGALLOW_BIT];
    assign rate_on = ctrl_q[`PMC_CTRL_RATE_LSB +: `PMC_CTRL_RATE_W] != `PMC_CTRL_RATE_OFF;
    assign status_word = {24'h0, sync_cnt_q, illegal_op_reset_q, state_q};

    // Command classification
    assign in_halt = state_q == pmc_pkg::PMC_ST_HALT;
    assign in_low = state_q == pmc_pkg::PMC_ST_WAIT || state_q == pmc_pkg::PMC_ST_STOP;
    assign halt_cmd = dbg_cmd_valid && dbg_cmd_halt;
    assign status_cmd = dbg_cmd_class == pmc_pkg::PMC_DBG_STATUS;
    assign class_ok = in_halt
        || (state_q == pmc_pkg::PMC_ST_RUN && dbg_cmd_class != pmc_pkg::PMC_DBG_ACTIVE)
        || (in_low && (status_cmd || dbg_cmd_halt));
    assign go_cmd = dbg_cmd_valid && !dbg_cmd_halt && in_halt
        && dbg_cmd_class == pmc_pkg::PMC_DBG_ACTIVE && debug_halt_instruction == 1'b0
        && breakpoint_match == 1'b0 && dbg_cmd_class == pmc_pkg::PMC_DBG_ACTIVE;

    // Wake qualification on synchronised requests
    assign async_hit = |(wake_bus.async_wake & wake_en_q[`PMC_WAKE_W-1:0]);
    assign stop_wake = async_hit || (wake_bus.periodic_wake && rate_on);
    assign reset_exit = state_q == pmc_pkg::PMC_ST_STOP && wake_bus.reset_pin_wake;
    assign enter_halt = halt_cmd || debug_halt_instruction || breakpoint_match;
    assign ilop = state_q == pmc_pkg::PMC_ST_RUN && stop_instruction && !stop_enable_bit;

    always_comb begin
        state_d = state_q;
        case (state_q)
            pmc_pkg::PMC_ST_RESET: begin
                if (mode_select_debug_pin) state_d = pmc_pkg::PMC_ST_RUN;
                else if (por_flag || debug_force_reset_cmd) state_d = pmc_pkg::PMC_ST_HALT;
                else state_d = pmc_pkg::PMC_ST_RUN;
            end
            pmc_pkg::PMC_ST_RUN: begin
                if (debug_force_reset_cmd) state_d = pmc_pkg::PMC_ST_RESET;
                else if (enter_halt) state_d = pmc_pkg::PMC_ST_HALT;
                else if (wait_instruction) state_d = pmc_pkg::PMC_ST_WAIT;
                else if (stop_instruction && stop_enable_bit) state_d = pmc_pkg::PMC_ST_STOP;
                else if (ilop) state_d = pmc_pkg::PMC_ST_RESET;
            end
            pmc_pkg::PMC_ST_HALT: begin
                if (debug_force_reset_cmd) state_d = pmc_pkg::PMC_ST_RESET;
                else if (go_cmd) state_d = pmc_pkg::PMC_ST_RUN;
            end
            pmc_pkg::PMC_ST_WAIT: begin
                if (halt_cmd) state_d = pmc_pkg::PMC_ST_HALT;
                else if (irq_request || stop_wake) state_d = pmc_pkg::PMC_ST_RUN;
            end
            pmc_pkg::PMC_ST_STOP: begin
                if (reset_exit) state_d = pmc_pkg::PMC_ST_RESET;
                else if (halt_cmd && dbg_allow) state_d = pmc_pkg::PMC_ST_HALT;
                else if (stop_wake) state_d = pmc_pkg::PMC_ST_RUN;
            end
            default: state_d = pmc_pkg::PMC_ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) state_q <= pmc_pkg::PMC_ST_RESET;
        else state_q <= state_d;
    end

    // Wake settle count in the low-power states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sync_cnt_q <= 2'h0;
        else if (in_low && sync_cnt_q != 2'(`PMC_SYNC_CYC)) sync_cnt_q <= sync_cnt_q + 2'h1;
        else if (!in_low) sync_cnt_q <= 2'h0;
    end

    // Clock, regulator and pin control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_en_q <= 1'b0;
            sys_clk_en_q <= 1'b1;
            dbg_clk_en_q <= 1'b1;
            clkgen_en_q <= 1'b1;
            ref_clk_en_q <= 1'b0;
            wake_osc_en_q <= 1'b0;
            reg_full_q <= 1'b1;
            pin_hold_q <= 1'b0;
        end else begin
            cpu_clk_en_q <= state_d == pmc_pkg::PMC_ST_RUN;
            sys_clk_en_q <= state_d != pmc_pkg::PMC_ST_STOP;
            dbg_clk_en_q <= state_d != pmc_pkg::PMC_ST_STOP || dbg_allow;
            clkgen_en_q <= state_d != pmc_pkg::PMC_ST_STOP || dbg_allow
                || (ref_keep && lv_stop);
            ref_clk_en_q <= ref_keep && (state_d != pmc_pkg::PMC_ST_STOP || lv_stop);
            wake_osc_en_q <= rate_on;
            reg_full_q <= state_d != pmc_pkg::PMC_ST_STOP || dbg_allow || lv_stop;
            pin_hold_q <= state_d == pmc_pkg::PMC_ST_WAIT
                || state_d == pmc_pkg::PMC_ST_STOP;
        end
    end

    // Restart strobes to the CPU
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            restart_q <= 1'b0;
            restart_addr_q <= `PMC_RESET_START_ADDR;
            pc_advance_q <= 1'b0;
            illegal_op_reset_q <= 1'b0;
        end else begin
            restart_q <= state_q == pmc_pkg::PMC_ST_RESET
                && state_d == pmc_pkg::PMC_ST_RUN;
            restart_addr_q <= `PMC_RESET_START_ADDR;
            pc_advance_q <= in_low && state_d == pmc_pkg::PMC_ST_RUN;
            illegal_op_reset_q <= ilop;
        end
    end

    // Debug command answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_cmd_accept_q <= 1'b0;
            dbg_cmd_err_q <= 1'b0;
            dbg_mem_allow_q <= 1'b0;
        end else begin
            dbg_cmd_accept_q <= dbg_cmd_valid && class_ok;
            dbg_cmd_err_q <= dbg_cmd_valid && in_low && status_cmd;
            dbg_mem_allow_q <= dbg_cmd_valid && class_ok && !in_low
                && dbg_cmd_class != pmc_pkg::PMC_DBG_ACTIVE;
        end
    end

    AST_ILOP_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        ilop |=> illegal_op_reset_q && state_q == pmc_pkg::PMC_ST_RESET)
        else $error("Stop without enable did not force reset");
    AST_STOP_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_RUN && stop_instruction && stop_enable_bit && !enter_halt
        && !wait_instruction && !debug_force_reset_cmd
        |=> state_q == pmc_pkg::PMC_ST_STOP && !sys_clk_en_q && !cpu_clk_en_q)
        else $error("Stop entry did not halt clocks");
    AST_WAIT_CLK: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_WAIT |-> !cpu_clk_en_q && sys_clk_en_q && reg_full_q)
        else $error("Wait clocking wrong");
    AST_WAIT_HALT: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_WAIT && halt_cmd |=> state_q == pmc_pkg::PMC_ST_HALT)
        else $error("Halt request in wait not honoured");
    AST_ACTIVE_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
        dbg_cmd_valid && !in_halt && dbg_cmd_class == pmc_pkg::PMC_DBG_ACTIVE
        && !dbg_cmd_halt |=> !dbg_cmd_accept_q)
        else $error("Active command accepted outside debug-halt");
    AST_LOW_STATUS_ERR: assert property (@(posedge clk) disable iff (!rst_n)
        dbg_cmd_valid && in_low && status_cmd |=> dbg_cmd_err_q && !dbg_mem_allow_q)
        else $error("Status command in low power not flagged");
    AST_HALT_SUSPEND: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_HALT [*2] |-> !cpu_clk_en_q)
        else $error("CPU clocked while halted");
    AST_RATE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !rate_on [*2] |-> !wake_osc_en_q)
        else $error("Wake oscillator on with rate zero");
    AST_STOP_REG: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_STOP && $stable(ctrl_q) && (lv_stop || dbg_allow)
        |-> reg_full_q)
        else $error("Regulator in standby with hold bits set");
    AST_WAKE_ADV: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_WAIT && irq_request && !halt_cmd
        |=> pc_advance_q && cpu_clk_en_q)
        else $error("Wait exit without advance");

    COV_STOP_WAKE: cover property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_STOP ##1 state_q == pmc_pkg::PMC_ST_RUN);
    COV_WAIT_WAKE: cover property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_WAIT ##1 state_q == pmc_pkg::PMC_ST_RUN);
    COV_HALT_GO: cover property (@(posedge clk) disable iff (!rst_n)
        state_q == pmc_pkg::PMC_ST_HALT ##1 state_q == pmc_pkg::PMC_ST_RUN);
    COV_ILOP: cover property (@(posedge clk) disable iff (!rst_n) illegal_op_reset_q);
endmodule : pmc_mode_ctrl

//--- pmc_params.svh
/*
 * Constants of the power mode controller: register offsets, field
 * positions, reset values and timing counts.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_RESET_START_ADDR 14'h3ffd
`define PMC_ADDR_W 14

`define PMC_CTRL_OFFSET 12'h000
`define PMC_STATUS_OFFSET 12'h004
`define PMC_WAKE_EN_OFFSET 12'h008

`define PMC_CTRL_RESET 32'h0000_0000
`define PMC_WAKE_EN_RESET 32'h0000_0000

`define PMC_CTRL_STOP_ENABLE_BIT_BIT 0
`define PMC_CTRL_REFKEEP_BIT 1
`define PMC_CTRL_LOWVOLT_DETECT_ENABLE_BIT 2
`define PMC_CTRL_LOWVOLT_STOP_ENABLE_BIT 3
`define PMC_CTRL_DBGALLOW_BIT 4
`define PMC_CTRL_RATE_LSB 8
`define PMC_CTRL_RATE_W 3
`define PMC_CTRL_RATE_OFF 3'h0

`define PMC_WAKE_KBI_BIT 0
`define PMC_WAKE_LVD_BIT 1
`define PMC_WAKE_ANALOG_COMPARATOR_BIT 2
`define PMC_WAKE_W 3

`define PMC_CLK_MHZ 40
`define PMC_SYNC_NS 50
`define PMC_SYNC_CYC ((`PMC_SYNC_NS * `PMC_CLK_MHZ + 999) / 1000)

`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

//--- pmc_pkg.sv
/*
 * Types shared by the power mode controller files.
 * Assumes pmc_params.svh is compiled alongside.
 */
package pmc_pkg;

    typedef enum logic [4:0] {
        PMC_ST_RESET = 5'h01,
        PMC_ST_RUN = 5'h02,
        PMC_ST_HALT = 5'h04,
        PMC_ST_WAIT = 5'h08,
        PMC_ST_STOP = 5'h10
    } pmc_state_t;

    typedef enum logic [1:0] {
        PMC_DBG_NONINTR = 2'h0,
        PMC_DBG_STATUS = 2'h1,
        PMC_DBG_ACTIVE = 2'h2,
        PMC_DBG_NONE = 2'h3
    } pmc_dbg_class_t;

endpackage : pmc_pkg

//--- pmc_wake_if.sv
/*
 * Carrier for synchronised wake requests between the wake synchroniser
 * and the mode controller.
 * Assumes one producer and one consumer on the same clock.
 */
`include "pmc_params.svh"

interface pmc_wake_if;
    logic [`PMC_WAKE_W-1:0] async_wake;
    logic periodic_wake;
    logic reset_pin_wake;

    modport src (
        output async_wake,
        output periodic_wake,
        output reset_pin_wake
    );
    modport dst (
        input async_wake,
        input periodic_wake,
        input reset_pin_wake
    );
endinterface : pmc_wake_if

//--- pmc_wake_sync.sv
/*
 * Two-stage synchronisers for every wake request.
 * Assumes clk is the bus clock; inputs may be asynchronous.
 */
`include "pmc_params.svh"

module pmc_wake_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`PMC_WAKE_W-1:0] async_in,
    input wire logic periodic_in,
    input wire logic reset_pin_in,
    pmc_wake_if.src wake
);
    localparam int N = `PMC_WAKE_W + 2;
    logic [N-1:0] raw;
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;

    assign raw = {reset_pin_in, periodic_in, async_in};

    // Synchronise every asynchronous wake request
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign wake.async_wake = sync_q[`PMC_WAKE_W-1:0];
    assign wake.periodic_wake = sync_q[`PMC_WAKE_W];
    assign wake.reset_pin_wake = sync_q[`PMC_WAKE_W+1];
endmodule : pmc_wake_sync

//--- pmc_axi_regs.sv
/*
 * AXI4-Lite slave holding the control and wake-enable registers and
 * returning the mode status word.
 * Assumes one outstanding write and one outstanding read.
 */
`include "pmc_params.svh"

module pmc_axi_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] status_word,
    output logic [31:0] ctrl_q,
    output logic [31:0] wake_en_q
);
    logic aw_held_q;
    logic w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] wmask;
    logic do_write;
    logic wr_ctrl;
    logic wr_wake;
    logic wr_hit;
    logic rd_ctrl;
    logic rd_stat;
    logic rd_wake;
    logic [31:0] rd_data;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_ctrl = awaddr_q == `PMC_CTRL_OFFSET;
    assign wr_wake = awaddr_q == `PMC_WAKE_EN_OFFSET;
    assign wr_hit = wr_ctrl || wr_wake || awaddr_q == `PMC_STATUS_OFFSET;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_ctrl = s_axi_araddr == `PMC_CTRL_OFFSET;
    assign rd_stat = s_axi_araddr == `PMC_STATUS_OFFSET;
    assign rd_wake = s_axi_araddr == `PMC_WAKE_EN_OFFSET;
    assign rd_data = rd_ctrl ? ctrl_q : rd_stat ? status_word : rd_wake ? wake_en_q : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `PMC_CTRL_RESET;
            wake_en_q <= `PMC_WAKE_EN_RESET;
        end else if (do_write) begin
            if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
            if (wr_wake) wake_en_q <= (wake_en_q & ~wmask) | (wdata_q & wmask);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `PMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= (rd_ctrl || rd_stat || rd_wake) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : pmc_axi_regs

//--- pmc_dbg_host.sv
/* Debug host model: mode pin level and one-cycle debug commands.
   Assumes the bench calls send from its main sequence. */
module pmc_dbg_host (
    input wire logic clk,
    output logic mode_select_debug_pin,
    output logic dbg_cmd_valid,
    output logic [1:0] dbg_cmd_class,
    output logic dbg_cmd_halt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mode_select_debug_pin = 1'b1; // Pulled high, so no forced halt
        dbg_cmd_valid = 1'b0;
        dbg_cmd_class = 2'h3;
        dbg_cmd_halt = 1'b0;
    end
    task automatic send(input logic [1:0] c, input logic h); // Active class only in halt
        @(posedge clk);
        dbg_cmd_valid <= 1'b1;
        dbg_cmd_class <= c;
        dbg_cmd_halt <= h;
        @(posedge clk);
        dbg_cmd_valid <= 1'b0;
        dbg_cmd_class <= 2'h3;
        dbg_cmd_halt <= 1'b0;
    endtask : send
endmodule : pmc_dbg_host

//--- tb_top.sv
/* Bench for the mode controller: boot, stop, wait and halt.
   Assumes pmc_params.svh and the design files compile first. */
`include "pmc_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, por_flag, debug_force_reset_cmd, dbg_cmd_valid, dbg_cmd_halt;
    logic mode_select_debug_pin, debug_halt_instruction, breakpoint_match, wait_instruction;
    logic stop_instruction, irq_request, periodic_wake_req, reset_pin_req, s_axi_awvalid;
    logic s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_clk_en_q, sys_clk_en_q, dbg_clk_en_q;
    logic clkgen_en_q, ref_clk_en_q, wake_osc_en_q, reg_full_q, pin_hold_q, restart_q;
    logic pc_advance_q, illegal_op_reset_q, dbg_cmd_accept_q, dbg_cmd_err_q, dbg_mem_allow_q;
    logic [1:0] dbg_cmd_class, s_axi_bresp, s_axi_rresp;
    logic [`PMC_WAKE_W-1:0] async_wake_req;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [`PMC_ADDR_W-1:0] restart_addr_q;
    int fail_count = 0, checks_done = 0, cyc = 0, n_rs = 0, n_il = 0, n_pc = 0;
    pmc_mode_ctrl dut (.*);
    pmc_dbg_host host (.clk(clk), .mode_select_debug_pin(mode_select_debug_pin),
        .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_class(dbg_cmd_class), .dbg_cmd_halt(dbg_cmd_halt));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        n_rs += int'(restart_q === 1'b1);
        n_il += int'(illegal_op_reset_q === 1'b1);
        n_pc += int'(pc_advance_q === 1'b1);
        if (cyc == 5000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, 32'h0);
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(rd, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask : axr
    task automatic t_stop();
        axw(`PMC_CTRL_OFFSET, 32'h0000_0000);
        @(posedge clk) stop_instruction <= 1'b1;
        @(posedge clk) stop_instruction <= 1'b0;
        repeat (8) @(posedge clk);
        chk(n_il, 1);
        axw(`PMC_WAKE_EN_OFFSET, 32'h0000_0001);
        axw(`PMC_CTRL_OFFSET, 32'h0000_0001);
        @(posedge clk) stop_instruction <= 1'b1;
        @(posedge clk) stop_instruction <= 1'b0;
        repeat (3) @(posedge clk);
        chk({cpu_clk_en_q, sys_clk_en_q, pin_hold_q}, 3'h1);
        chk({dbg_clk_en_q, clkgen_en_q, ref_clk_en_q, wake_osc_en_q, reg_full_q}, 5'h0);
        async_wake_req <= 3'h1;
        repeat (6) @(posedge clk);
        chk(n_pc, 1);
        chk(cpu_clk_en_q, 1);
        async_wake_req <= 3'h0;
    endtask : t_stop
    task automatic t_wait();
        @(posedge clk) wait_instruction <= 1'b1;
        @(posedge clk) wait_instruction <= 1'b0;
        repeat (3) @(posedge clk);
        chk({cpu_clk_en_q, sys_clk_en_q}, 2'h1);
        host.send(2'h1, 1'b0);
        #1 chk({dbg_cmd_accept_q, dbg_cmd_err_q, dbg_mem_allow_q}, 3'h6);
        @(posedge clk) irq_request <= 1'b1;
        repeat (4) @(posedge clk);
        chk(n_pc, 2);
        chk(cpu_clk_en_q, 1);
        irq_request <= 1'b0;
    endtask : t_wait
    task automatic t_halt();
        host.send(2'h0, 1'b1);
        repeat (3) @(posedge clk);
        chk(cpu_clk_en_q, 0);
        axr(`PMC_STATUS_OFFSET, 32'h4, 2'h0);
        host.send(2'h2, 1'b0);
        #1 chk(dbg_cmd_accept_q, 1);
        axr(12'hffc, 32'h0, 2'h2);
    endtask : t_halt
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        {rst_n, por_flag, debug_force_reset_cmd, debug_halt_instruction} = 4'h0;
        {breakpoint_match, wait_instruction, stop_instruction, irq_request} = 4'h0;
        {periodic_wake_req, reset_pin_req, async_wake_req, s_axi_wstrb} = 9'h00f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(n_rs, 1);
        chk({18'h0, restart_addr_q}, {18'h0, 14'h3ffd});
        axr(`PMC_STATUS_OFFSET, 32'h2, 2'h0);
        t_stop();
        t_wait();
        t_halt();
        final_report();
    end
endmodule : tb_top
